// ---- legacy_fp_control_status_regs.sv ----
`timescale 1ns/1ns
module legacy_fp_control_status_regs
  import lfp_pkg::*;
(
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             srst,
  // native application register access
  input  wire logic             ar_valid,
  input  wire logic             ar_wr,
  input  wire logic [6:0]       ar_num,
  input  wire logic [63:0]      ar_wdata,
  output logic      [63:0]      ar_rdata,
  output logic                  ar_rvalid,
  output logic                  ar_fault,
  // legacy word access
  input  wire logic             leg_valid,
  input  wire logic             leg_wr,
  input  wire leg_word_type     leg_sel,
  input  wire logic [31:0]      leg_wdata,
  output logic      [31:0]      leg_rdata,
  output logic                  leg_rvalid,
  // legacy datapath
  input  wire logic [15:0]      stack_class,
  input  wire exec_update_type  ex,
  input  wire logic             fp_issue,
  output control_view_type      fp_ctl,
  output logic                  delayed_exc
);

  state_type s_r;
  state_type s_nxt;
  logic      ar_hit;
  logic      ar_is_ctl;
  logic [63:0] ctl_now;
  logic [63:0] sts_now;

  // native image of the control register
  function automatic logic [63:0] ctl_view(input state_type s);
    logic [63:0] v;
    v = '0;
    v[12:0] = s.stack_fpu_control_word;
    v[POS_VMASK +: 6] = s.vmask;
    v[POS_VROUND +: 2] = s.vround;
    v[POS_FLUSH] = s.flush;
    return v;
  endfunction

  // native image of the status register; ignored and reserved bits read zero
  function automatic logic [63:0] sts_view(input state_type s);
    logic [63:0] v;
    v = '0;
    v[5:0] = s.flags;
    v[POS_SF] = s.stack_fault;
    v[POS_ES] = s.err_sum;
    v[POS_CC_LO +: 3] = s.cc[2:0];
    v[POS_TOP +: 3] = s.top;
    v[POS_CC3] = s.cc[3];
    v[POS_BUSY] = s.err_sum;
    for (int i = 0; i < 8; i++) begin
      v[POS_TAG0 + 2*i] = s.tag_empty[i];
    end
    v[POS_VFLAG +: 6] = s.vflags;
    return v;
  endfunction

  // legacy full tag word: classes come from the stack_class input
  function automatic logic [15:0] tag_full(input state_type s, input logic [15:0] cls);
    logic [15:0] v;
    v = '0;
    for (int i = 0; i < 8; i++) begin
      v[2*i +: 2] = s.tag_empty[i] ? TAG_EMPTY : cls[2*i +: 2];
    end
    return v;
  endfunction

  assign ar_is_ctl = (ar_num == AR_NUM_CTL);
  assign ar_hit    = ar_valid && (ar_is_ctl || ar_num == AR_NUM_STS);
  assign ctl_now   = ctl_view(s_r);
  assign sts_now   = sts_view(s_r);

  // next state: native access, then legacy word access, then retiring flags
  always_comb begin
    s_nxt = s_r;
    s_nxt.ar_rvalid = 1'b0;
    s_nxt.ar_fault = 1'b0;
    s_nxt.leg_rvalid = 1'b0;
    // a written summary bit is honoured regardless of the flags
    s_nxt.delayed_exc = fp_issue && s_r.err_sum;
    if (ar_hit) begin
      s_nxt.ar_rvalid = 1'b1;
      if (!ar_wr) begin
        s_nxt.ar_rdata = ar_is_ctl ? ctl_now : sts_now;
      end else if (ar_is_ctl) begin
        if ((ar_wdata & CTL_RSV_MASK) != '0) begin
          s_nxt.ar_fault = 1'b1;
        end else begin
          // bits 37:32 are ignored and simply dropped
          s_nxt.stack_fpu_control_word = ar_wdata[12:0];
          s_nxt.vmask = ar_wdata[POS_VMASK +: 6];
          s_nxt.vround = ar_wdata[POS_VROUND +: 2];
          s_nxt.flush = ar_wdata[POS_FLUSH];
        end
      end else begin
        if ((ar_wdata & STS_RSV_MASK) != '0) begin
          s_nxt.ar_fault = 1'b1;
        end else begin
          // busy bit, odd tag bits and 47:39 have no storage
          s_nxt.flags = ar_wdata[5:0];
          s_nxt.stack_fault = ar_wdata[POS_SF];
          s_nxt.err_sum = ar_wdata[POS_ES];
          s_nxt.cc = {ar_wdata[POS_CC3], ar_wdata[POS_CC_LO +: 3]};
          s_nxt.top = ar_wdata[POS_TOP +: 3];
          for (int i = 0; i < 8; i++) begin
            s_nxt.tag_empty[i] = ar_wdata[POS_TAG0 + 2*i];
          end
          s_nxt.vflags = ar_wdata[POS_VFLAG +: 6];
        end
      end
    end
    // legacy words alias the same storage, no shadow copy
    if (leg_valid) begin
      s_nxt.leg_rvalid = 1'b1;
      if (!leg_wr) begin
        unique case (leg_sel)
          LW_CTL: s_nxt.leg_rdata = {19'h0, s_r.stack_fpu_control_word};
          LW_STS: s_nxt.leg_rdata = {16'h0, sts_now[15:0]};
          LW_TAG: s_nxt.leg_rdata = {16'h0, tag_full(s_r, stack_class)};
          LW_VEC: s_nxt.leg_rdata = {16'h0, s_r.flush, s_r.vround, s_r.vmask,
                                     1'b0, s_r.vflags};
        endcase
      end else begin
        unique case (leg_sel)
          LW_CTL: s_nxt.stack_fpu_control_word = leg_wdata[12:0];
          LW_STS: begin
            s_nxt.flags = leg_wdata[5:0];
            s_nxt.stack_fault = leg_wdata[POS_SF];
            s_nxt.err_sum = leg_wdata[POS_ES];
            s_nxt.cc = {leg_wdata[POS_CC3], leg_wdata[POS_CC_LO +: 3]};
            s_nxt.top = leg_wdata[POS_TOP +: 3];
          end
          LW_TAG: begin
            // only emptiness is kept; classes are recomputed on read
            for (int i = 0; i < 8; i++) begin
              s_nxt.tag_empty[i] = (leg_wdata[2*i +: 2] == TAG_EMPTY);
            end
          end
          LW_VEC: begin
            s_nxt.vflags = leg_wdata[5:0];
            s_nxt.vmask = leg_wdata[VW_MASK +: 6];
            s_nxt.vround = leg_wdata[VW_ROUND +: 2];
            s_nxt.flush = leg_wdata[VW_FLUSH];
          end
        endcase
      end
    end
    // only legacy execution feeds these flags; sticky, so a set beats any write
    if (ex.valid) begin
      s_nxt.flags = s_nxt.flags | ex.fpu_flags;
      s_nxt.stack_fault = s_nxt.stack_fault | ex.stack_fault;
      s_nxt.vflags = s_nxt.vflags | ex.vec_flags;
      s_nxt.err_sum = s_nxt.err_sum | ex.stack_fault
                      | (|(s_nxt.flags & ~s_nxt.stack_fpu_control_word[5:0]));
      if (ex.cc_we) begin
        s_nxt.cc = ex.cc;
      end
      if (ex.top_we) begin
        s_nxt.top = ex.top;
      end
      if (ex.tag_we) begin
        s_nxt.tag_empty = ex.tag_empty;
      end
    end
  end

  // state register with a defined reset image
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_r <= '0;
      s_r.stack_fpu_control_word <= RST_FCW;
      s_r.vmask <= RST_VMASK;
      s_r.vround <= RST_VROUND;
      s_r.flush <= RST_FLUSH;
      s_r.tag_empty <= RST_TAGS;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state
  assign ar_rdata    = s_r.ar_rdata;
  assign ar_rvalid   = s_r.ar_rvalid;
  assign ar_fault    = s_r.ar_fault;
  assign leg_rdata   = s_r.leg_rdata;
  assign leg_rvalid  = s_r.leg_rvalid;
  assign delayed_exc = s_r.delayed_exc;
  assign fp_ctl      = '{stack_fpu_control_word: s_r.stack_fpu_control_word, vmask: s_r.vmask, vround: s_r.vround,
                         flush: s_r.flush, top: s_r.top, tag_empty: s_r.tag_empty};

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  AST_RESERVED_FAULT: assert property (
    ar_valid && ar_wr && ar_num == AR_NUM_CTL && ar_wdata[63:48] != 16'h0000
    |=> ar_fault && ar_rvalid)
    else $error("reserved non-zero write did not fault");
  AST_FAULT_NO_STORE: assert property (
    ar_valid && ar_wr && ar_num == AR_NUM_CTL && (ar_wdata & CTL_RSV_MASK) != '0
    && !leg_valid |=> ctl_now == $past(ctl_now))
    else $error("faulting write changed the control register");
  AST_IGNORED_ZERO: assert property (
    ar_valid && !ar_wr && ar_num == AR_NUM_STS
    |=> ar_rdata[47:38] == 10'h000 && ar_rdata[63:48] == 16'h0000)
    else $error("ignored or reserved status bits read non-zero");
  AST_BUSY_MIRROR: assert property (
    leg_valid && !leg_wr && leg_sel == LW_STS |=> leg_rdata[15] == leg_rdata[7])
    else $error("busy bit differs from error summary");
  AST_ODD_TAG_ZERO: assert property (
    ar_valid && !ar_wr && ar_num == AR_NUM_STS
    |=> (ar_rdata[31:16] & 16'hAAAA) == 16'h0000
        && ar_rdata[16] == $past(s_r.tag_empty[0]))
    else $error("tag layout wrong on native read");
  AST_CLASSIFIED_TAG: assert property (
    leg_valid && !leg_wr && leg_sel == LW_TAG && !s_r.tag_empty[1]
    |=> leg_rdata[3:2] == $past(stack_class[3:2]))
    else $error("legacy tag word lost its classification");
  AST_SUMMARY_TRAP: assert property (
    ar_valid && ar_wr && ar_num == AR_NUM_STS && ar_wdata[7]
    && (ar_wdata & STS_RSV_MASK) == '0 && !leg_valid ##1 fp_issue
    |=> delayed_exc)
    else $error("written summary did not trap the next legacy instruction");
  AST_FLAGS_STICKY: assert property (
    ex.valid && ex.fpu_flags[2] |=> sts_now[2] ##1 (sts_now[2] || $past(ar_valid || leg_valid)))
    else $error("retired flag not held in status");
  AST_VEC_FLAGS: assert property (
    ex.valid && ex.vec_flags[5] |=> sts_now[37])
    else $error("vector flag missing at bit 37");
  AST_TOP_FIELD: assert property (
    ex.valid && ex.top_we |=> sts_now[13:11] == $past(ex.top))
    else $error("top pointer not at bits 13:11");
  AST_SHARED_VIEW: assert property (
    leg_valid && leg_wr && leg_sel == LW_CTL && !ar_valid
    |=> ctl_now[12:0] == $past(leg_wdata[12:0]) && fp_ctl.stack_fpu_control_word == ctl_now[12:0])
    else $error("legacy control write not seen by native view");
  AST_RESET_IMAGE: assert property (disable iff (1'b0)
    $past(srst) |-> ctl_now[12:0] == RST_FCW && sts_now[5:0] == 6'h00)
    else $error("reset image wrong");

  COV_FAULT:   cover property (ar_fault);
  COV_TRAP:    cover property (delayed_exc);
  COV_TAGREAD: cover property (leg_valid && !leg_wr && leg_sel == LW_TAG ##1 leg_rvalid);
  COV_STICKY:  cover property (ex.valid && ar_valid && ar_wr && ar_num == AR_NUM_STS);
endmodule

// ---- lfp_pkg.sv ----
// What this block does
// - control: stack control bits 12:0, vector control high
// - status: six flags, stack fault 6, summary 7
// - top pointer 13:11, condition codes 8,9,10,14
// - busy bit 15 mirrors error summary, no storage
// - empty tag i at bit 16+2i, odd zero
// - native reads empty only; legacy reads classified tags
// - vector flags at status bits 37:32
// - ignored fields drop writes, read zero
// - reserved fields fault on non-zero write, read zero
// - native unit status never touches these bits
// - legacy execution updates these bits directly
// - legacy and native views share identical bits
// - native summary read returns last stored value
// - summary set raises fault on next legacy instruction
// - both registers 64 bits, numbers 21 and 28
package lfp_pkg;
  // application register numbers
  localparam logic [6:0]  AR_NUM_CTL     = 7'h15;
  localparam logic [6:0]  AR_NUM_STS     = 7'h1C;
  // status field positions
  localparam int          POS_SF         = 6;
  localparam int          POS_ES         = 7;
  localparam int          POS_CC_LO      = 8;
  localparam int          POS_TOP        = 11;
  localparam int          POS_CC3        = 14;
  localparam int          POS_BUSY       = 15;
  localparam int          POS_TAG0       = 16;
  localparam int          POS_VFLAG      = 32;
  // control field positions
  localparam int          POS_VMASK      = 39;
  localparam int          POS_VROUND     = 45;
  localparam int          POS_FLUSH      = 47;
  // legacy vector word positions
  localparam int          VW_MASK        = 7;
  localparam int          VW_ROUND       = 13;
  localparam int          VW_FLUSH       = 15;
  // reserved bits of each register (ignored bits are not in these)
  localparam logic [63:0] CTL_RSV_MASK   = 64'hFFFF_0040_FFFF_E000;
  localparam logic [63:0] STS_RSV_MASK   = 64'hFFFF_0040_0000_0000;
  // reset values
  localparam logic [12:0] RST_FCW        = 13'h037F;
  localparam logic [5:0]  RST_VMASK      = 6'h3F;
  localparam logic [1:0]  RST_VROUND     = 2'h0;
  localparam logic        RST_FLUSH      = 1'b0;
  localparam logic [7:0]  RST_TAGS       = 8'hFF;
  // full tag word classes
  localparam logic [1:0]  TAG_VALID      = 2'h0;
  localparam logic [1:0]  TAG_ZERO       = 2'h1;
  localparam logic [1:0]  TAG_SPECIAL    = 2'h2;
  localparam logic [1:0]  TAG_EMPTY      = 2'h3;

  typedef enum logic [1:0] {LW_CTL, LW_STS, LW_TAG, LW_VEC} leg_word_type;

  // one legacy instruction retiring
  typedef struct packed {
    logic       valid;
    logic [5:0] fpu_flags;
    logic       stack_fault;
    logic       cc_we;
    logic [3:0] cc;
    logic       top_we;
    logic [2:0] top;
    logic       tag_we;
    logic [7:0] tag_empty;
    logic [5:0] vec_flags;
  } exec_update_type;

  // settings that steer the legacy datapath
  typedef struct packed {
    logic [12:0] stack_fpu_control_word;
    logic [5:0]  vmask;
    logic [1:0]  vround;
    logic        flush;
    logic [2:0]  top;
    logic [7:0]  tag_empty;
  } control_view_type;

  typedef struct packed {
    logic [12:0] stack_fpu_control_word;
    logic [5:0]  vmask;
    logic [1:0]  vround;
    logic        flush;
    logic [5:0]  flags;
    logic        stack_fault;
    logic        err_sum;
    logic [3:0]  cc;
    logic [2:0]  top;
    logic [7:0]  tag_empty;
    logic [5:0]  vflags;
    logic [63:0] ar_rdata;
    logic        ar_rvalid;
    logic        ar_fault;
    logic [31:0] leg_rdata;
    logic        leg_rvalid;
    logic        delayed_exc;
  } state_type;
endpackage

// ---- legacy_fp_control_status_regs_tb.sv ----
`timescale 1ns/1ns
module legacy_fp_control_status_regs_tb;
  import lfp_pkg::*;
  logic             ref_clk;
  logic             srst;
  logic             ar_valid;
  logic             ar_wr;
  logic [6:0]       ar_num;
  logic [63:0]      ar_wdata;
  logic [63:0]      ar_rdata;
  logic             ar_rvalid;
  logic             ar_fault;
  logic             leg_valid;
  logic             leg_wr;
  leg_word_type     leg_sel;
  logic [31:0]      leg_wdata;
  logic [31:0]      leg_rdata;
  logic             leg_rvalid;
  logic [15:0]      stack_class;
  exec_update_type  ex;
  logic             fp_issue;
  control_view_type fp_ctl;
  logic             delayed_exc;
  int               num_errors;
  int               check_count;

  legacy_fp_control_status_regs dut (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .ar_valid    (ar_valid),
    .ar_wr       (ar_wr),
    .ar_num      (ar_num),
    .ar_wdata    (ar_wdata),
    .ar_rdata    (ar_rdata),
    .ar_rvalid   (ar_rvalid),
    .ar_fault    (ar_fault),
    .leg_valid   (leg_valid),
    .leg_wr      (leg_wr),
    .leg_sel     (leg_sel),
    .leg_wdata   (leg_wdata),
    .leg_rdata   (leg_rdata),
    .leg_rvalid  (leg_rvalid),
    .stack_class (stack_class),
    .ex          (ex),
    .fp_issue    (fp_issue),
    .fp_ctl      (fp_ctl),
    .delayed_exc (delayed_exc)
  );

  // 50 MHz core clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] expd);
    check_count++;
    if (seen !== expd) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one native access; answer is registered, so it is looked at one edge on
  task automatic ar_op(input logic wr, input logic [6:0] num, input logic [63:0] wd);
    @(posedge ref_clk);
    #2;
    ar_valid = 1'b1;
    ar_wr    = wr;
    ar_num   = num;
    ar_wdata = wd;
    @(posedge ref_clk);
    #2;
    ar_valid = 1'b0;
  endtask

  task automatic ar_write(input logic [6:0] num, input logic [63:0] wd, input logic flt);
    ar_op(1'b1, num, wd);
    check(ar_rvalid, 1'b1);
    check(ar_fault, flt);
  endtask

  task automatic ar_read(input logic [6:0] num, input logic [63:0] expd);
    ar_op(1'b0, num, 64'h0);
    check(ar_rvalid, 1'b1);
    check(ar_rdata, expd);
  endtask

  task automatic leg_op(input logic wr, input leg_word_type sel, input logic [31:0] wd);
    @(posedge ref_clk);
    #2;
    leg_valid = 1'b1;
    leg_wr    = wr;
    leg_sel   = sel;
    leg_wdata = wd;
    @(posedge ref_clk);
    #2;
    leg_valid = 1'b0;
    check(leg_rvalid, 1'b1);
  endtask

  // pulses fp_issue and checks whether the delayed trap followed as expected
  task automatic issue(input logic expd);
    @(posedge ref_clk);
    #2;
    fp_issue = 1'b1;
    @(posedge ref_clk);
    #2;
    fp_issue = 1'b0;
    check(delayed_exc, expd);
  endtask

  // one retiring legacy instruction
  task automatic retire(input exec_update_type u);
    @(posedge ref_clk);
    #2;
    ex = u;
    @(posedge ref_clk);
    #2;
    ex = '0;
  endtask

  task automatic test_reset();
    ar_read(AR_NUM_CTL, 64'h0000_1F80_0000_037F);
    ar_read(AR_NUM_STS, 64'h0000_0000_5555_0000);
    check(fp_ctl.stack_fpu_control_word, 13'h037F);
    check(fp_ctl.vmask, 6'h3F);
    check(fp_ctl.tag_empty, 8'hFF);
    issue(1'b0);
    $display("test reset done");
  endtask

  // ignored bits dropped, busy mirrors summary, legacy views agree
  task automatic test_fields();
    ar_write(AR_NUM_STS, 64'h0000_FFBF_FFFF_FFFF, 1'b0);
    ar_read(AR_NUM_STS, 64'h0000_003F_5555_FFFF);
    leg_op(1'b0, LW_STS, 32'h0);
    check(leg_rdata, 32'h0000_FFFF);
    leg_op(1'b0, LW_VEC, 32'h0);
    check(leg_rdata, 32'h0000_1FBF);
    issue(1'b1);
    $display("test fields done");
  endtask

  // a write with any reserved bit set faults and stores nothing
  task automatic test_reserved();
    ar_write(AR_NUM_STS, 64'h0000_0040_0000_0000, 1'b1);
    ar_write(AR_NUM_STS, 64'h0001_0000_0000_0000, 1'b1);
    ar_write(AR_NUM_CTL, 64'h0000_0000_0000_2000, 1'b1);
    ar_read(AR_NUM_STS, 64'h0000_003F_5555_FFFF);
    ar_read(AR_NUM_CTL, 64'h0000_1F80_0000_037F);
    ar_op(1'b0, 7'h1D, 64'h0);
    check(ar_rvalid, 1'b0);
    $display("test reserved done");
  endtask

  // execution sets flags, codes and top directly in the status register
  task automatic test_exec();
    exec_update_type u;
    u = '0;
    // both registers loaded with a sane image before any legacy instruction retires
    ar_write(AR_NUM_CTL, 64'h0000_1F80_0000_037B, 1'b0);
    ar_write(AR_NUM_STS, 64'h0000_0000_5555_0000, 1'b0);
    issue(1'b0);
    u.valid     = 1'b1;
    u.fpu_flags = 6'h04;
    u.cc_we     = 1'b1;
    u.cc        = 4'hF;
    u.top_we    = 1'b1;
    u.top       = 3'h5;
    u.vec_flags = 6'h01;
    retire(u);
    ar_read(AR_NUM_STS, 64'h0000_0001_5555_EF84);
    check(fp_ctl.top, 3'h5);
    check(fp_ctl.stack_fpu_control_word, 13'h037B);
    issue(1'b1);
    $display("test exec done");
  endtask

  // native view sees only empty tags, legacy tag word gets classes
  task automatic test_tags();
    exec_update_type u;
    u = '0;
    u.valid     = 1'b1;
    u.tag_we    = 1'b1;
    u.tag_empty = 8'hF0;
    retire(u);
    ar_read(AR_NUM_STS, 64'h0000_0001_5500_EF84);
    stack_class = 16'h0049;
    leg_op(1'b0, LW_TAG, 32'h0);
    check(leg_rdata, 32'h0000_FF49);
    leg_op(1'b1, LW_CTL, 32'h0000_1234);
    ar_read(AR_NUM_CTL, 64'h0000_1F80_0000_1234);
    leg_op(1'b0, LW_CTL, 32'h0);
    check(leg_rdata, 32'h0000_1234);
    $display("test tags done");
  endtask

  // legacy status, tag and vector writes land in the shared native bits
  task automatic test_legacy_words();
    leg_op(1'b1, LW_STS, 32'h0000_1AC1);
    leg_op(1'b1, LW_TAG, 32'h0000_2FC3);
    leg_op(1'b1, LW_VEC, 32'h0000_CAEA);
    ar_read(AR_NUM_STS, 64'h0000_002A_0541_9AC1);
    ar_read(AR_NUM_CTL, 64'h0000_CA80_0000_1234);
    check(fp_ctl.tag_empty, 8'h39);
    check(fp_ctl.vmask, 6'h15);
    check(fp_ctl.vround, 2'h2);
    check(fp_ctl.flush, 1'b1);
    leg_op(1'b0, LW_VEC, 32'h0);
    check(leg_rdata, 32'h0000_CAAA);
    leg_op(1'b0, LW_TAG, 32'h0);
    check(leg_rdata, 32'h0000_0FCB);
    $display("test legacy words done");
  endtask

  // summary written with all flags clear must still trap the very next issue
  task automatic trap_after_write();
    @(posedge ref_clk);
    #2;
    ar_valid = 1'b1;
    ar_wr    = 1'b1;
    ar_num   = AR_NUM_STS;
    ar_wdata = 64'h0000_0000_0000_0080;
    @(posedge ref_clk);
    #2;
    ar_valid = 1'b0;
    fp_issue = 1'b1;
    check(ar_rvalid, 1'b1);
    @(posedge ref_clk);
    #2;
    fp_issue = 1'b0;
    check(delayed_exc, 1'b1);
  endtask

  // a native clear and a retiring instruction in one cycle: the set flags win
  task automatic test_collide();
    exec_update_type u;
    u = '0;
    u.valid       = 1'b1;
    u.stack_fault = 1'b1;
    u.fpu_flags   = 6'h08;
    u.vec_flags   = 6'h10;
    @(posedge ref_clk);
    #2;
    ar_valid = 1'b1;
    ar_wr    = 1'b1;
    ar_num   = AR_NUM_STS;
    ar_wdata = 64'h0;
    ex       = u;
    @(posedge ref_clk);
    #2;
    ar_valid = 1'b0;
    ex       = '0;
    check(ar_rvalid, 1'b1);
    ar_read(AR_NUM_STS, 64'h0000_0010_0000_80C8);
    ar_write(AR_NUM_STS, 64'h0, 1'b0);
    issue(1'b0);
    trap_after_write();
    ar_write(AR_NUM_CTL, 64'h0001_0000_0000_0000, 1'b1);
    ar_read(AR_NUM_CTL, 64'h0000_CA80_0000_1234);
    $display("test collide done");
  endtask

  // hang guard: a run this long counts as a failure
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    $display("mismatch at %0t: run did not complete", $time);
    stop_test();
  end

  initial begin
    num_errors  = 0;
    check_count = 0;
    srst        = 1'b1;
    ar_valid    = 1'b0;
    ar_wr       = 1'b0;
    ar_num      = 7'h00;
    ar_wdata    = 64'h0;
    leg_valid   = 1'b0;
    leg_wr      = 1'b0;
    leg_sel     = LW_CTL;
    leg_wdata   = 32'h0;
    stack_class = 16'h0000;
    ex          = '0;
    fp_issue    = 1'b0;
    repeat (8) @(posedge ref_clk);
    #2;
    srst = 1'b0;
    test_reset();
    test_fields();
    test_reserved();
    test_exec();
    test_tags();
    test_legacy_words();
    test_collide();
    stop_test();
  end
endmodule
